/* src/exc_ctrl_defines.vh */
// Summary of operation
// - write one sets nonmaskable pending, takes precedence
// - nonmaskable set bit reads pending state
// - deferred service set bit sets, reads pending
// - deferred service clear bit removes pending
// - tick set bit sets, reads pending
// - tick clear bit removes pending
// - preempt flag: pending taken on debug exit
// - external pending flag: any external irq pending
// - pending vector: highest priority pending, zero none
// - pending vector uses enables, ignores priority mask
// - active vector zero in thread mode
// - byte order flag reads zero always
// - reset request bit asserts system reset output
// - clear active bit wipes all active state
`ifndef EXC_CTRL_DEFINES_VH
`define EXC_CTRL_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ICS_OFFSET        12'hD04
`define AIRC_OFFSET       12'hD0C
`define SYSCTL_OFFSET     12'hD10
`define ICS_RESET         32'h00000000
`define AIRC_RESET        32'h00000000
`define SYSCTL_RESET      32'h00000000

// ---------------------------------------------------------------
// interrupt control/state word fields
// ---------------------------------------------------------------
`define NMI_SET_BIT       31
`define PSV_SET_BIT       28
`define PSV_CLR_BIT       27
`define TICK_SET_BIT      26
`define TICK_CLR_BIT      25
`define PREEMPT_BIT       23
`define EXT_PEND_BIT      22
`define VPEND_HI          20
`define VPEND_LO          12
`define VACT_HI           8
`define VACT_LO           0

// ---------------------------------------------------------------
// reset control word fields
// ---------------------------------------------------------------
`define KEY_HI            31
`define KEY_LO            16
`define KEY_VALUE         16'h05FA
`define BYTE_ORDER_BIT    15
`define RESET_REQ_BIT     2
`define CLR_ACTIVE_BIT    1
`define SYSCTL_MASK       32'h00000016

// ---------------------------------------------------------------
// exception numbers
// ---------------------------------------------------------------
`define EXC_NMI           9'h002
`define EXC_PSV           9'h00E
`define EXC_TICK          9'h00F
`define EXC_EXT_BASE      9'h010

`endif

/* src/ext_irq_pick.v */
`timescale 1ns/1ps
`include "exc_ctrl_defines.vh"
// ---------------------------------------------------------------
// lowest-numbered enabled pending external interrupt
// ---------------------------------------------------------------
module ext_irq_pick #(
  parameter N = 32
) (
  input  wire [N-1:0] pend,     // external pending lines
  input  wire [N-1:0] enable,   // enable mask
  output reg          any,      // some enabled line pending
  output reg  [8:0]   number    // exception number of winner
);
  integer i;
  // scan downward so the lowest index wins
  always @* begin
    any    = 1'b0;
    number = 9'h000;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (pend[i] && enable[i]) begin
        any    = 1'b1;
        number = `EXC_EXT_BASE + i[8:0];
      end
    end
  end
endmodule

/* src/active_tracker.v */
`timescale 1ns/1ps
`include "exc_ctrl_defines.vh"
// ---------------------------------------------------------------
// holds number of executing exception, zero in thread mode
// ---------------------------------------------------------------
module active_tracker (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       enter,       // core enters handler, pulse
  input  wire [8:0] enter_num,   // number being entered
  input  wire       leave,       // core returns to thread, pulse
  input  wire       clear_all,   // wipe active state, pulse
  output reg  [8:0] active_num   // executing exception number
);
  // ---------------------------------------------------------------
  // clear wins, then entry, then leave
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      active_num <= 9'h000;
    end else if (clear_all) begin
      active_num <= 9'h000;
    end else if (enter) begin
      active_num <= enter_num;
    end else if (leave) begin
      active_num <= 9'h000;
    end
  end
endmodule

/* src/exception_control_state_regs.v */
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "exc_ctrl_defines.vh"
// ---------------------------------------------------------------
// exception control and status registers on avalon-mm
// ---------------------------------------------------------------
module exception_control_state_regs #(
  parameter N_EXT = 32
) (
  input  wire             clk,
  input  wire             rst_n,
  // avalon-mm slave
  input  wire [11:0]      address,         // byte address
  input  wire             read,
  input  wire             write,
  input  wire [31:0]      writedata,
  input  wire [3:0]       byteenable,
  output reg  [31:0]      readdata,
  output wire             waitrequest,
  output reg  [1:0]       response,        // 00 ok, 10 slave error
  // core side
  input  wire [N_EXT-1:0] ext_pend,        // external irq pending lines
  input  wire [N_EXT-1:0] ext_enable,      // external irq enables
  input  wire             tick_event,      // tick timer fires, pulse
  input  wire             nmi_event,       // nonmaskable source, pulse
  input  wire             core_enter,      // core enters exception
  input  wire [8:0]       core_enter_num,  // number being entered
  input  wire             core_leave,      // core returns to thread
  input  wire             debug_halted,    // core halted in debug
  output reg              nmi_pending,     // nonmaskable pending
  output reg              psv_pending,     // deferred service pending
  output reg              tick_pending,    // tick pending
  output reg              sys_reset_req,   // reset request to system
  output reg              clear_active,    // active wipe pulse
  output reg  [31:0]      sys_control      // sleep-control word
);
  // ---------------------------------------------------------------
  // bus handshake: one wait cycle per access
  // ---------------------------------------------------------------
  reg        ack;      // answer cycle
  wire       req;      // request present
  wire       wr_go;    // write takes effect
  assign req         = read | write;
  assign waitrequest = req & ~ack;
  assign wr_go       = write & ack;

  // ack rises one cycle after request, drops after acceptance
  always @(posedge clk) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire sel_ics;    // control/state word
  wire sel_airc;   // reset control word
  wire sel_scr;    // sleep control word
  wire full_word;  // all byte lanes
  assign sel_ics   = (address == `ICS_OFFSET);
  assign sel_airc  = (address == `AIRC_OFFSET);
  assign sel_scr   = (address == `SYSCTL_OFFSET);
  assign full_word = (byteenable == 4'hF);

  // write strobes for the control/state and reset control words
  wire ics_wr;     // write hits control/state word
  wire key_ok;     // correct key present
  wire airc_wr;    // keyed write to reset control
  assign ics_wr  = wr_go & sel_ics;
  assign key_ok  = (writedata[`KEY_HI:`KEY_LO] == `KEY_VALUE) && byteenable[3] && byteenable[2];
  assign airc_wr = wr_go & sel_airc & key_ok;

  // ---------------------------------------------------------------
  // external and pending vector selection
  // ---------------------------------------------------------------
  wire       ext_any;   // some enabled external pending
  wire [8:0] ext_num;   // its exception number
  wire [8:0] act_num;   // active exception number

  // enables applied here; priority mask never seen
  ext_irq_pick #(
    .N      (N_EXT)
  ) u_pick (
    .pend   (ext_pend),
    .enable (ext_enable),
    .any    (ext_any),
    .number (ext_num)
  );

  active_tracker u_active (
    .clk        (clk),
    .rst_n      (rst_n),
    .enter      (core_enter),
    .enter_num  (core_enter_num),
    .leave      (core_leave),
    .clear_all  (clear_active),
    .active_num (act_num)
  );

  // fixed order: nonmaskable, deferred service, tick, external
  function [8:0] pick_vector;
    input       n;
    input       p;
    input       t;
    input       e;
    input [8:0] en;
    begin
      if (n) begin
        pick_vector = `EXC_NMI;
      end else if (p) begin
        pick_vector = `EXC_PSV;
      end else if (t) begin
        pick_vector = `EXC_TICK;
      end else if (e) begin
        pick_vector = en;
      end else begin
        pick_vector = 9'h000;
      end
    end
  endfunction

  wire [8:0] vpend;     // highest priority pending number
  wire       any_pend;  // anything pending
  assign vpend    = pick_vector(nmi_pending, psv_pending, tick_pending, ext_any, ext_num);
  assign any_pend = (vpend != 9'h000);

  // ---------------------------------------------------------------
  // pending flags: hardware set beats software clear
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      nmi_pending  <= 1'b0;
      psv_pending  <= 1'b0;
      tick_pending <= 1'b0;
    end else begin
      // nonmaskable: set by software or source, cleared on entry
      if (nmi_event || (ics_wr && writedata[`NMI_SET_BIT])) begin
        nmi_pending <= 1'b1;
      end else if (core_enter && core_enter_num == `EXC_NMI) begin
        nmi_pending <= 1'b0;
      end
      // deferred service: set wins over clear, zero ignored
      if (ics_wr && writedata[`PSV_SET_BIT]) begin
        psv_pending <= 1'b1;
      end else if (ics_wr && writedata[`PSV_CLR_BIT]) begin
        psv_pending <= 1'b0;
      end else if (core_enter && core_enter_num == `EXC_PSV) begin
        psv_pending <= 1'b0;
      end
      // tick: event or software set, zero writes ignored
      if (tick_event || (ics_wr && writedata[`TICK_SET_BIT])) begin
        tick_pending <= 1'b1;
      end else if (ics_wr && writedata[`TICK_CLR_BIT]) begin
        tick_pending <= 1'b0;
      end else if (core_enter && core_enter_num == `EXC_TICK) begin
        tick_pending <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // reset request, active wipe and sleep control word
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      sys_reset_req <= 1'b0;
      clear_active  <= 1'b0;
      sys_control   <= `SYSCTL_RESET;
    end else begin
      // request held until system reset arrives
      if (airc_wr && writedata[`RESET_REQ_BIT]) begin
        sys_reset_req <= 1'b1;
      end
      // one-cycle wipe; only meaningful while halted in debug
      clear_active <= airc_wr & writedata[`CLR_ACTIVE_BIT];
      if (wr_go && sel_scr && full_word) begin
        sys_control <= writedata & `SYSCTL_MASK;
      end
    end
  end

  // ---------------------------------------------------------------
  // read data and response, registered on the answer edge
  // ---------------------------------------------------------------
  reg [31:0] next_readdata;  // decoded read word
  reg        next_bad;       // unmapped address

  always @* begin
    next_readdata = 32'h00000000;
    next_bad      = 1'b0;
    if (sel_ics) begin
      next_readdata[`NMI_SET_BIT]           = nmi_pending;
      next_readdata[`PSV_SET_BIT]           = psv_pending;
      next_readdata[`TICK_SET_BIT]          = tick_pending;
      next_readdata[`PREEMPT_BIT]           = any_pend & debug_halted;
      next_readdata[`EXT_PEND_BIT]          = |ext_pend;
      next_readdata[`VPEND_HI:`VPEND_LO]    = vpend;
      next_readdata[`VACT_HI:`VACT_LO]      = act_num;
    end else if (sel_airc) begin
      next_readdata[`BYTE_ORDER_BIT]        = 1'b0;
      next_readdata[`RESET_REQ_BIT]         = sys_reset_req;
    end else if (sel_scr) begin
      next_readdata = sys_control;
    end else begin
      next_bad = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      readdata <= 32'h00000000;
      response <= 2'h0;
    end else if (req && !ack) begin
      readdata <= read ? next_readdata : 32'h00000000;
      response <= next_bad ? 2'h2 : 2'h0;
    end
  end
endmodule

/* tb/exc_regs_chk_sva.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// register side checker
// ---------------------------------------------------------------
module exc_regs_chk #(
  parameter N_EXT = 32
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic [11:0]      address,
  input wire logic             read,
  input wire logic             write,
  input wire logic [31:0]      writedata,
  input wire logic [3:0]       byteenable,
  input wire logic [31:0]      readdata,
  input wire logic             waitrequest,
  input wire logic [N_EXT-1:0] ext_pend,
  input wire logic [N_EXT-1:0] ext_enable,
  input wire logic             tick_event,
  input wire logic             nmi_event,
  input wire logic             core_enter,
  input wire logic             nmi_pending,
  input wire logic             psv_pending,
  input wire logic             tick_pending,
  input wire logic             sys_reset_req,
  input wire logic             clear_active
);
  wire rd      = read && !waitrequest;                 // read answered
  wire ics_w   = write && !waitrequest && address == 12'hD04;
  wire key_w   = write && !waitrequest && address == 12'hD0C && writedata[31:16] == 16'h05FA && byteenable == 4'hF;
  wire idle    = !(|(ext_pend & ext_enable)) && !nmi_pending && !psv_pending && !tick_pending;
  wire ext_any = |ext_pend;                            // any external line
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_nmi_set: assert property (ics_w && writedata[31] |=> nmi_pending) else $error("nmi set lost");
  chk_psv_set: assert property (ics_w && writedata[28] |=> psv_pending) else $error("psv set lost");
  chk_psv_clr: assert property (ics_w && writedata[27] && !writedata[28] |=> !psv_pending)
    else $error("psv clear lost");
  chk_tick_set: assert property (ics_w && writedata[26] |=> tick_pending) else $error("tick set lost");
  chk_tick_clr: assert property (ics_w && writedata[25] && !writedata[26] && !tick_event |=> !tick_pending)
    else $error("tick clear lost");
  chk_zero_hold: assert property (ics_w && writedata[31:25] == 7'h00 && !tick_event && !nmi_event && !core_enter
    |=> $stable(psv_pending) && $stable(tick_pending) && $stable(nmi_pending)) else $error("zero write moved");
  chk_no_pend: assert property (rd && address == 12'hD04 && $past(idle) |-> readdata[20:12] == 9'h000)
    else $error("vector not zero");
  chk_ext_flag: assert property (rd && address == 12'hD04 |-> readdata[22] == $past(ext_any))
    else $error("external flag wrong");
  chk_byte_order: assert property (rd && address == 12'hD0C |-> readdata[15] == 1'b0) else $error("byte order set");
  chk_rst_req: assert property (key_w && writedata[2] |=> sys_reset_req) else $error("reset request lost");
  chk_clr_pulse: assert property (key_w && writedata[1] |=> clear_active ##1 !clear_active)
    else $error("clear pulse wrong");
  cover property (ics_w && writedata[31]);
  cover property (key_w && writedata[2]);
  cover property (rd && address == 12'hD08);
endmodule

bind exception_control_state_regs exc_regs_chk #(.N_EXT(N_EXT)) chk_i (.*);

/* tb/core_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// core side: takes pending exceptions, returns dly+1 cycles after entry
// ---------------------------------------------------------------
module core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       take,            // core may take exceptions
  input  wire logic [3:0] dly,             // cycles spent in handler, minus one
  input  wire logic       nmi_pending,
  input  wire logic       psv_pending,
  input  wire logic       tick_pending,
  input  wire logic       clear_active,
  output logic            core_enter,
  output logic [8:0]      core_enter_num,
  output logic            core_leave
);
  logic       busy;                        // handler running
  logic [3:0] cnt;                         // cycles left
  // enter highest pending, leave later, drop on active wipe
  always @(posedge clk) begin
    core_enter <= 1'b0;
    core_leave <= 1'b0;
    if (!rst_n || clear_active) begin
      busy <= 1'b0;
      core_enter_num <= 9'h000;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h0) begin
        busy <= 1'b0;
        core_leave <= 1'b1;
      end
    end else if (take && (nmi_pending || psv_pending || tick_pending)) begin
      busy <= 1'b1;
      cnt <= dly;
      core_enter <= 1'b1;
      core_enter_num <= nmi_pending ? 9'h002 : (psv_pending ? 9'h00E : 9'h00F);
    end
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] address = 12'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0]  byteenable = 4'hF;
  logic [7:0]  ext_pend = 8'h00;
  logic [7:0]  ext_enable = 8'h00;
  logic        tick_event = 1'b0;
  logic        nmi_event = 1'b0;
  logic        debug_halted = 1'b0;
  logic        take = 1'b0;
  logic [3:0]  dly = 4'hF;
  wire  [31:0] readdata, sys_control;
  wire  [1:0]  response;
  wire         waitrequest, nmi_pending, psv_pending, tick_pending, sys_reset_req, clear_active, core_enter, core_leave;
  wire  [8:0]  core_enter_num;
  logic [65:0] q[$];                       // expected {response, mask, data}
  logic [65:0] e;
  logic [31:0] seed = 32'hE4460BD4;
  logic [31:0] rnd, ex;
  logic [8:0]  v;
  int          mismatches = 0, n_tests = 0, n_clr = 0, cyc = 0, i, k, s;

  exception_control_state_regs #(.N_EXT(8)) dut (.*);
  core_model cm (.*);

  always #10 clk = ~clk;

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one bus cycle, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, m, x, input logic [1:0] r = 2'b00);
    q.push_back({r, m, x});
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    @(posedge clk);
    while (waitrequest) @(posedge clk);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // take the oldest note whenever a transfer is answered
  always @(posedge clk) begin
    cyc++;
    if (clear_active) n_clr++;
    if ((read || write) && !waitrequest) begin
      e = q.pop_front();
      chk({response, readdata & e[63:32]}, {e[65:64], e[31:0]});
    end
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, 12'hD04, 0, 32'hFFFFFFFF, 0);
    acc(0, 12'hD0C, 0, 32'hFFFFFFFF, 0);
    acc(0, 12'hD10, 0, 32'hFFFFFFFF, 0);
    acc(0, 12'hD08, 0, 32'hFFFFFFFF, 0, 2'b10);
    $display("test reset values done");
    debug_halted <= 1'b1;
    for (i = 0; i < 2; i++) begin
      s = i ? 26 : 28;
      ex = (32'h1 << s) | (i ? 32'h0080F000 : 32'h0080E000);
      acc(1, 12'hD04, 32'h1 << s, 0, 0);
      acc(0, 12'hD04, 0, (32'h1 << s) | 32'h009FF000, ex);
      acc(1, 12'hD04, 0, 0, 0);
      acc(0, 12'hD04, 0, (32'h1 << s) | 32'h009FF000, ex);
      acc(1, 12'hD04, 32'h1 << (s - 1), 0, 0);
      acc(0, 12'hD04, 0, 32'h1E9FF000, 0);
    end
    $display("test deferred and tick done");
    debug_halted <= 1'b0;
    acc(1, 12'hD04, 32'h80000000, 0, 0);
    acc(0, 12'hD04, 0, 32'h809FF1FF, 32'h80002000);
    take <= 1'b1;
    @(posedge clk iff core_enter);
    take <= 1'b0;
    acc(0, 12'hD04, 0, 32'h809FF1FF, 32'h00000002);
    @(posedge clk iff core_leave);
    acc(0, 12'hD04, 0, 32'h000001FF, 0);
    $display("test nonmaskable done");
    acc(1, 12'hD04, 32'h80000000, 0, 0);
    take <= 1'b1;
    @(posedge clk iff core_enter);
    take <= 1'b0;
    debug_halted <= 1'b1;
    acc(1, 12'hD0C, 32'h12340002, 0, 0);
    chk(n_clr, 0);
    acc(1, 12'hD0C, 32'h05FA8002, 0, 0);
    acc(0, 12'hD04, 0, 32'h000001FF, 0);
    acc(0, 12'hD0C, 0, 32'h00008000, 0);
    chk(n_clr, 1);
    debug_halted <= 1'b0;
    $display("test clear active done");
    for (i = 0; i < 8; i++) begin
      rnd = $random(seed);
      ext_pend <= rnd[7:0];
      ext_enable <= rnd[15:8];
      @(posedge clk);
      v = 9'h000;
      for (k = 7; k >= 0; k--) begin
        if (ext_pend[k] && ext_enable[k]) v = 9'h010 + k[8:0];
      end
      acc(0, 12'hD04, 0, 32'h005FF000, {|ext_pend, 1'b0, v, 12'h000});
    end
    $display("test external lines done");
    acc(1, 12'hD10, 32'hFFFFFFFF, 0, 0);
    acc(0, 12'hD10, 0, 32'hFFFFFFFF, 32'h00000016);
    chk({2'h0, sys_control}, 34'h000000016);
    $display("test sleep control word done");
    acc(1, 12'hD0C, 32'h05FA0004, 0, 0);
    @(posedge clk);
    chk({33'h0, sys_reset_req}, 34'h1);
    $display("test reset request done");
    report_and_stop();
  end
endmodule
